// ==== src/bmh_params.svh ====
`ifndef BMH_PARAMS_SVH
`define BMH_PARAMS_SVH
// ----------------------------------------
// Timing figures in their own units
// ----------------------------------------
`define BMH_CLK_MHZ 25
`define BMH_DEAD_NS 200
`define BMH_CHOP_OFF_US 25
`define BMH_CHOP_BLANK_US 2
`define BMH_DEGLITCH_NS 600
`define BMH_SLEEP_US 1000
`define BMH_WAKE_FILT_US 5
`define BMH_WAKE_DELAY_US 23
`define BMH_UV_DEGLITCH_US 10
`define BMH_OC_DEGLITCH_NS 1500
`define BMH_OC_RETRY_US 3000
// ----------------------------------------
// Cycle counts derived from the 25 MHz clock
// ----------------------------------------
`define BMH_DEAD_CYC ((`BMH_DEAD_NS * `BMH_CLK_MHZ + 999) / 1000)
`define BMH_CHOP_OFF_CYC (`BMH_CHOP_OFF_US * `BMH_CLK_MHZ)
`define BMH_CHOP_BLANK_CYC (`BMH_CHOP_BLANK_US * `BMH_CLK_MHZ)
`define BMH_DEGLITCH_CYC ((`BMH_DEGLITCH_NS * `BMH_CLK_MHZ + 999) / 1000)
`define BMH_SLEEP_CYC (`BMH_SLEEP_US * `BMH_CLK_MHZ)
`define BMH_WAKE_FILT_CYC (`BMH_WAKE_FILT_US * `BMH_CLK_MHZ)
`define BMH_WAKE_DELAY_CYC (`BMH_WAKE_DELAY_US * `BMH_CLK_MHZ)
`define BMH_UV_DEGLITCH_CYC (`BMH_UV_DEGLITCH_US * `BMH_CLK_MHZ)
`define BMH_OC_DEGLITCH_CYC ((`BMH_OC_DEGLITCH_NS * `BMH_CLK_MHZ + 999) / 1000)
`define BMH_OC_RETRY_CYC (`BMH_OC_RETRY_US * `BMH_CLK_MHZ)
`endif

// ==== src/bmh_pkg.sv ====
package bmh_pkg;
  // Main operating states, one-hot
  typedef enum logic [4:0] {
    BMH_SLEEP = 5'h01,
    BMH_WAKE  = 5'h02,
    BMH_RUN   = 5'h04,
    BMH_CHOP  = 5'h08,
    BMH_FAULT = 5'h10
  } bmh_state_t;
  // Requested leg level: low, high or floating
  typedef enum logic [2:0] {
    BMH_LEG_OFF  = 3'h1,
    BMH_LEG_LOW  = 3'h2,
    BMH_LEG_HIGH = 3'h4
  } bmh_leg_t;
endpackage

// ==== src/bmh_filter.sv ====
`timescale 1ns/1ps
// Persistence filter: out rises after in held high for COUNT cycles,
// falls at once when in drops. Output comes from a flip-flop.
module bmh_filter #(
  parameter int COUNT = 10
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic level_i,
  output logic held_o
);
  localparam int W = $clog2(COUNT + 1);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic held;
  } bmh_filt_st_t;
  bmh_filt_st_t st, next_st;

  // ----------------------------------------
  // Count while high
  // ----------------------------------------
  always_comb begin
    next_st = st;
    if (!level_i) begin
      next_st.cnt = '0;
      next_st.held = 1'b0;
    end else if (st.cnt >= W'(COUNT - 1)) begin
      next_st.held = 1'b1;
    end else begin
      next_st.cnt = st.cnt + W'(1);
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign held_o = st.held;
endmodule // bmh_filter

// ==== src/bmh_leg.sv ====
`timescale 1ns/1ps
// One half-bridge leg with break-before-make dead time. A change of
// side first turns both switches off, then waits DEAD cycles.
module bmh_leg #(
  parameter int DEAD = 5
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire bmh_pkg::bmh_leg_t req_i,
  output logic hs_on_o,
  output logic ls_on_o
);
  localparam int W = $clog2(DEAD + 1);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic hs;
    logic ls;
  } bmh_leg_st_t;
  bmh_leg_st_t st, next_st;

  // ----------------------------------------
  // Dead-time sequencing
  // ----------------------------------------
  always_comb begin
    logic want_hs;
    logic want_ls;
    want_hs = (req_i == bmh_pkg::BMH_LEG_HIGH);
    want_ls = (req_i == bmh_pkg::BMH_LEG_LOW);
    next_st = st;
    if (st.cnt != '0) begin
      next_st.cnt = st.cnt - W'(1);
    end
    if ((st.hs && !want_hs) || (st.ls && !want_ls)) begin
      // Turn off immediately; opposite side waits the dead time
      next_st.hs = 1'b0;
      next_st.ls = 1'b0;
      next_st.cnt = W'(DEAD);
    end else if (st.cnt == '0 && !st.hs && !st.ls) begin
      next_st.hs = want_hs;
      next_st.ls = want_ls;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign hs_on_o = st.hs;
  assign ls_on_o = st.ls;
endmodule // bmh_leg

// ==== src/bmh_ctrl.sv ====
`timescale 1ns/1ps
`include "bmh_params.svh"
module bmh_ctrl #(
  parameter int SLEEP_CYC = `BMH_SLEEP_CYC,
  parameter int RETRY_CYC = `BMH_OC_RETRY_CYC
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic dir_input_a_i,
  input wire logic dir_input_b_i,
  input wire logic current_trip_i,
  input wire logic overcurrent_i,
  input wire logic undervoltage_i,
  input wire logic overtemp_i,
  output logic bridge_a_hs_o,
  output logic bridge_a_ls_o,
  output logic bridge_b_hs_o,
  output logic bridge_b_ls_o,
  output logic asleep_o,
  output logic fault_flag_n_o,
  output logic fault_flag_n_oe_o
);
  // Timer width: wide enough for the 3 ms retry count at 25 MHz (75000);
  // a longer retry or a faster clock needs it widened.
  localparam int TW = 17;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Every pin and comparator result is asynchronous to the clock. Two
  // flops per bit keep metastability out of the counters. The price is
  // two cycles (80 ns) of extra latency on every reaction. That is small
  // against the shortest figure that matters, the 200 ns dead time.
  // The six bits are synchronised independently, so a change on both
  // direction pins at once may be seen one cycle apart. The blanking
  // restart on any input change absorbs that skew.
  logic [5:0] sync1;
  logic [5:0] sync2;
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {overtemp_i, undervoltage_i, overcurrent_i, current_trip_i,
                dir_input_b_i, dir_input_a_i};
      sync2 <= sync1;
    end
  end
  logic in_a, in_b, trip_raw, oc_raw, uv_raw, ot_raw;
  assign {ot_raw, uv_raw, oc_raw, trip_raw, in_b, in_a} = sync2;

  // ----------------------------------------
  // Persistence filters
  // ----------------------------------------
  // Each filter needs its input high on every clock for the full count and
  // drops at once, so a single low sample restarts the deglitch. Counts are
  // rounded up to whole cycles, so nothing is ever accepted early.
  // The wake filter looks at either input, so a burst on one pin alone
  // still wakes the bridge once one high phase lasts the full filter time.
  logic trip_ok, oc_held, uv_held, wake_held;
  bmh_filter #(.COUNT(`BMH_DEGLITCH_CYC)) u_trip_filt (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .level_i(trip_raw),
    .held_o(trip_ok)
  );
  bmh_filter #(.COUNT(`BMH_OC_DEGLITCH_CYC)) u_oc_filt (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .level_i(oc_raw),
    .held_o(oc_held)
  );
  bmh_filter #(.COUNT(`BMH_UV_DEGLITCH_CYC)) u_uv_filt (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .level_i(uv_raw),
    .held_o(uv_held)
  );
  bmh_filter #(.COUNT(`BMH_WAKE_FILT_CYC)) u_wake_filt (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .level_i(in_a | in_b),
    .held_o(wake_held)
  );

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  // Both direction inputs low: fast decay request and sleep countdown
  function automatic logic bmh_idle(input logic a, input logic b);
    return !a && !b;
  endfunction

  // Exactly one input high: the only drive that chopping regulates, since
  // brake and fast decay already let the current fall
  function automatic logic bmh_single(input logic a, input logic b);
    return a ^ b;
  endfunction

  // ----------------------------------------
  // Controller state
  // ----------------------------------------
  typedef struct packed {
    bmh_pkg::bmh_state_t state;
    logic [TW-1:0] tmr;       // Wake, chop-off and blanking timer
    logic [TW-1:0] idle_cnt;  // Counts both-inputs-low time
    logic [TW-1:0] retry_cnt; // Overcurrent retry wait
    logic oc_lock;            // Overcurrent shutdown in progress
    logic [1:0] last_in;      // For blanking on input change
    logic flag_low;           // Registered open-drain enable
    logic asleep;             // Registered copy of the sleep state
  } bmh_ctrl_st_t;
  bmh_ctrl_st_t st, next_st;

  // Fault summary is combinational so the run-state leg requests drop in the same
  // cycle that the fault is seen; the legs still register it before the
  // pins, so the outputs stay glitch-free.
  logic fault_now;
  bmh_pkg::bmh_leg_t req_a, req_b;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    next_st = st;
    // The tmr field only counts down and the state decides what a zero means, so
    // one timer serves the wake delay, the chop off time and blanking.
    // Previous inputs, kept to restart blanking on any change
    next_st.last_in = {in_b, in_a};
    // Overcurrent lock with fixed retry; a fresh trip after retry relocks.
    // The filter output stays high while the comparator does, so a short
    // that is still present relocks on the first cycle after the retry,
    // before the legs can switch back on.
    if (st.oc_lock) begin
      if (st.retry_cnt >= TW'(RETRY_CYC - 1)) begin
        next_st.oc_lock = 1'b0;
        next_st.retry_cnt = '0;
      end else begin
        next_st.retry_cnt = st.retry_cnt + TW'(1);
      end
    end else if (oc_held) begin
      next_st.oc_lock = 1'b1;
      next_st.retry_cnt = '0;
    end
    fault_now = st.oc_lock || uv_held || ot_raw;
    next_st.flag_low = fault_now || (!st.oc_lock && oc_held);
    // Both-inputs-low timer for sleep entry; it saturates so a long idle
    // spell cannot wrap round and put off sleep
    if (!bmh_idle(in_a, in_b)) begin
      next_st.idle_cnt = '0;
    end else if (st.idle_cnt < TW'(SLEEP_CYC)) begin
      next_st.idle_cnt = st.idle_cnt + TW'(1);
    end
    if (st.tmr != '0) begin
      next_st.tmr = st.tmr - TW'(1);
    end
    unique case (st.state)
      // Only the wake filter leaves sleep; faults are flagged but wait
      bmh_pkg::BMH_SLEEP: begin
        if (wake_held) begin
          next_st.state = bmh_pkg::BMH_WAKE;
          next_st.tmr = TW'(`BMH_WAKE_DELAY_CYC);
        end
      end
      // Legs stay floating until the wake delay has run out
      bmh_pkg::BMH_WAKE: begin
        if (st.tmr == '0) begin
          next_st.state = bmh_pkg::BMH_RUN;
          next_st.tmr = TW'(`BMH_CHOP_BLANK_CYC);
        end
      end
      // Priority: fault, sleep entry, blanking restart, then chop
      bmh_pkg::BMH_RUN: begin
        if (fault_now) begin
          next_st.state = bmh_pkg::BMH_FAULT;
        end else if (st.idle_cnt >= TW'(SLEEP_CYC - 1) && bmh_idle(in_a, in_b)) begin
          next_st.state = bmh_pkg::BMH_SLEEP;
        end else if ({in_b, in_a} != st.last_in) begin
          next_st.tmr = TW'(`BMH_CHOP_BLANK_CYC);
        end else if (trip_ok && st.tmr == '0 && bmh_single(in_a, in_b)) begin
          next_st.state = bmh_pkg::BMH_CHOP;
          next_st.tmr = TW'(`BMH_CHOP_OFF_CYC);
        end
      end
      // Off time runs to its end even if the trip clears; inputs 00 end it
      bmh_pkg::BMH_CHOP: begin
        if (fault_now) begin
          next_st.state = bmh_pkg::BMH_FAULT;
        end else if (bmh_idle(in_a, in_b)) begin
          next_st.state = bmh_pkg::BMH_RUN;
          next_st.tmr = TW'(`BMH_CHOP_BLANK_CYC);
        end else if (st.tmr == '0) begin
          next_st.state = bmh_pkg::BMH_RUN;
          next_st.tmr = TW'(`BMH_CHOP_BLANK_CYC);
        end
      end
      // Recovery waits for every fault to clear, then blanks the inrush
      bmh_pkg::BMH_FAULT: begin
        if (!fault_now) begin
          next_st.state = bmh_pkg::BMH_RUN;
          next_st.tmr = TW'(`BMH_CHOP_BLANK_CYC);
        end
      end
      default: begin
        next_st.state = bmh_pkg::BMH_SLEEP;
      end
    endcase
    // Any fault forces the off state from every state except sleep
    if (fault_now && st.state != bmh_pkg::BMH_SLEEP) begin
      next_st.state = bmh_pkg::BMH_FAULT;
    end
    // Sleep output follows the state it will be in, so the pin and the
    // state register change on the same edge
    next_st.asleep = (next_st.state == bmh_pkg::BMH_SLEEP);
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st <= '{state: bmh_pkg::BMH_SLEEP, tmr: '0, idle_cnt: '0,
              retry_cnt: '0, oc_lock: 1'b0, last_in: 2'h0, flag_low: 1'b0,
              asleep: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Leg requests from state and inputs
  // ----------------------------------------
  // Chop forces both low sides on whatever the inputs say; only a fault,
  // inputs 00 or the end of the off time leaves it. Sleep, wake delay and fault all
  // leave both legs floating, which is also the safe default below.
  always_comb begin
    req_a = bmh_pkg::BMH_LEG_OFF;
    req_b = bmh_pkg::BMH_LEG_OFF;
    if (st.state == bmh_pkg::BMH_CHOP) begin
      req_a = bmh_pkg::BMH_LEG_LOW;
      req_b = bmh_pkg::BMH_LEG_LOW;
    end else if (st.state == bmh_pkg::BMH_RUN && !fault_now) begin
      unique case ({in_a, in_b})
        2'h2: begin
          req_a = bmh_pkg::BMH_LEG_HIGH;
          req_b = bmh_pkg::BMH_LEG_LOW;
        end
        2'h1: begin
          req_a = bmh_pkg::BMH_LEG_LOW;
          req_b = bmh_pkg::BMH_LEG_HIGH;
        end
        2'h3: begin
          req_a = bmh_pkg::BMH_LEG_LOW;
          req_b = bmh_pkg::BMH_LEG_LOW;
        end
        2'h0: begin
          req_a = bmh_pkg::BMH_LEG_OFF;
          req_b = bmh_pkg::BMH_LEG_OFF;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Half-bridges with dead time, registered outputs
  // ----------------------------------------
  // Each leg turns off at once and waits the dead time before the other
  // switch; going to float needs no wait. Rounding the dead time up to
  // whole cycles plus the settle cycle makes the gap six cycles, 240 ns.
  bmh_leg #(.DEAD(`BMH_DEAD_CYC)) u_leg_a (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .req_i(req_a),
    .hs_on_o(bridge_a_hs_o),
    .ls_on_o(bridge_a_ls_o)
  );
  bmh_leg #(.DEAD(`BMH_DEAD_CYC)) u_leg_b (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .req_i(req_b),
    .hs_on_o(bridge_b_hs_o),
    .ls_on_o(bridge_b_ls_o)
  );

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  // Open-drain flag: only ever drives low; the pull-up outside makes the
  // high level, so the enable alone carries the fault state
  assign fault_flag_n_o = 1'b0;
  assign fault_flag_n_oe_o = st.flag_low;
  // Straight from a flop, never decoded, so it cannot glitch on a change
  assign asleep_o = st.asleep;
endmodule // bmh_ctrl

// ==== bench/bmh_host.sv ====
`timescale 1ns/1ps
// Host side: a port register that sets both direction pins on the clock edge
module bmh_host (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [1:0] req_i,
  output logic dir_input_a_o,
  output logic dir_input_b_o
);
  // Callers space level changes 125 cycles or more apart, except the 100-cycle pulse and 60-cycle gaps in t_wake and t_sleep
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dir_input_a_o <= 1'b0;
      dir_input_b_o <= 1'b0;
    end else begin
      dir_input_a_o <= req_i[1];
      dir_input_b_o <= req_i[0];
    end
  end
endmodule // bmh_host

// ==== bench/bmh_ctrl_monitor.sv ====
`timescale 1ns/1ps
// Pin checks; windows follow the latencies of the controller
module bmh_ctrl_monitor (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic dir_input_a_i,
  input wire logic dir_input_b_i,
  input wire logic overtemp_i,
  input wire logic bridge_a_hs_o,
  input wire logic bridge_a_ls_o,
  input wire logic bridge_b_hs_o,
  input wire logic bridge_b_ls_o,
  input wire logic asleep_o,
  input wire logic fault_flag_n_oe_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);
  // No switch of the bridge conducts
  wire logic all_off = !(bridge_a_hs_o || bridge_a_ls_o || bridge_b_hs_o || bridge_b_ls_o);
  // --------------------------------
  // Assertions
  // --------------------------------
  chk_cross_leg_a: assert property (!(bridge_a_hs_o && bridge_a_ls_o))
    else $error("leg a shoot-through");
  chk_cross_leg_b: assert property (!(bridge_b_hs_o && bridge_b_ls_o))
    else $error("leg b shoot-through");
  chk_dead_leg_a: assert property ($rose(bridge_a_hs_o) |-> !$past(bridge_a_ls_o, 5))
    else $error("leg a dead time short");
  chk_dead_leg_b: assert property ($rose(bridge_b_ls_o) |-> !$past(bridge_b_hs_o, 5))
    else $error("leg b dead time short");
  chk_ot_flag: assert property (overtemp_i [*4] |-> ##[0:3] fault_flag_n_oe_o)
    else $error("overtemperature not flagged");
  chk_ot_float: assert property (overtemp_i [*8] |-> all_off)
    else $error("bridge on in overtemperature");
  chk_sleep_off: assert property (asleep_o |-> all_off)
    else $error("bridge on while asleep");
  chk_wake_hold: assert property ($fell(asleep_o) |-> all_off [*8])
    else $error("bridge on during wake delay");
  chk_zero_float: assert property ((!dir_input_a_i && !dir_input_b_i) [*6] |-> all_off)
    else $error("bridge on with both inputs low");
  chk_fault_float: assert property (fault_flag_n_oe_o [*3] |-> all_off)
    else $error("bridge on during fault");
  // Main scenarios seen
  cover property ($fell(asleep_o));
  cover property (bridge_a_ls_o && bridge_b_ls_o && dir_input_a_i && !dir_input_b_i);
  cover property ($rose(fault_flag_n_oe_o));
endmodule // bmh_ctrl_monitor

// ==== bench/tb_bmh_ctrl.sv ====
`timescale 1ns/1ps
module tb_bmh_ctrl;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  // Request in 5:4, then trip, overcurrent, undervoltage, overtemperature
  logic [5:0] drv = 6'h00;
  logic dir_a, dir_b, a_hs, a_ls, b_hs, b_ls, asleep, flag_n, flag_oe;
  wire logic [7:0] obs = {asleep, flag_oe, 2'h0, a_hs, a_ls, b_hs, b_ls};
  int n_mismatch = 0;
  int check_count = 0;
  int n = 0;
  // 25 MHz clock
  initial begin
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  bmh_host bmh_host_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .req_i(drv[5:4]),
    .dir_input_a_o(dir_a), .dir_input_b_o(dir_b));
  // Short sleep and retry counts keep the run brief
  bmh_ctrl #(.SLEEP_CYC(40), .RETRY_CYC(60)) bmh_ctrl_i (.sys_clk_i(sys_clk_i),
    .reset_i(reset_i), .dir_input_a_i(dir_a), .dir_input_b_i(dir_b),
    .current_trip_i(drv[3]), .overcurrent_i(drv[2]), .undervoltage_i(drv[1]),
    .overtemp_i(drv[0]), .bridge_a_hs_o(a_hs), .bridge_a_ls_o(a_ls),
    .bridge_b_hs_o(b_hs), .bridge_b_ls_o(b_ls), .asleep_o(asleep),
    .fault_flag_n_o(flag_n), .fault_flag_n_oe_o(flag_oe));
  // --------------------------------
  // Helpers
  // --------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk_i);
  endtask
  task automatic put(input logic [5:0] v);
    @(posedge sys_clk_i);
    drv <= v;
  endtask
  // Bounded wait; n tells how long it took
  task automatic wait_obs(input logic [7:0] m, input logic [7:0] v, input int lim);
    n = 0;
    while ((obs & m) !== v && n < lim) begin
      @(negedge sys_clk_i);
      n++;
    end
  endtask
  task automatic final_report();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_wake();
    put(6'h20);
    cyc(100);
    put(6'h00);
    cyc(60);
    chk("short pulse", asleep, 1'b1);
    put(6'h20);
    wait_obs(8'h80, 8'h00, 300);
    chk("wake filter", n >= 125 && n <= 135, 1'b1);
    wait_obs(8'h0F, 8'h09, 800);
    chk("wake hold", n >= 575 && n <= 585, 1'b1);
  endtask
  task automatic t_modes();
    put(6'h10);
    cyc(130);
    chk("reverse", obs, 8'h06);
    put(6'h30);
    cyc(130);
    chk("brake", obs, 8'h05);
    put(6'h28);
    cyc(30);
    put(6'h20);
    cyc(100);
    chk("blanked trip", obs, 8'h09);
    put(6'h28);
    cyc(10);
    put(6'h20);
    cyc(30);
    chk("short trip", obs, 8'h09);
    put(6'h28);
    wait_obs(8'h0F, 8'h05, 40);
    chk("trip delay", n >= 15 && n <= 30, 1'b1);
    put(6'h20);
    wait_obs(8'h0F, 8'h09, 700);
    chk("off time", n >= 610 && n <= 640, 1'b1);
  endtask
  task automatic t_sleep();
    put(6'h08);
    cyc(12);
    chk("fast decay", obs, 8'h00);
    cyc(18);
    chk("still awake", asleep, 1'b0);
    cyc(30);
    chk("asleep", asleep, 1'b1);
    put(6'h20);
    wait_obs(8'h0F, 8'h09, 900);
    chk("rewake", obs, 8'h09);
  endtask
  task automatic t_fault();
    put(6'h24);
    cyc(30);
    put(6'h20);
    cyc(10);
    chk("oc glitch", flag_oe, 1'b0);
    put(6'h24);
    wait_obs(8'h40, 8'h40, 60);
    chk("oc delay", n >= 38 && n <= 45, 1'b1);
    cyc(3);
    chk("oc off", obs, 8'h40);
    put(6'h20);
    wait_obs(8'h40, 8'h00, 80);
    chk("retry", n >= 53 && n <= 62, 1'b1);
    wait_obs(8'h0F, 8'h09, 150);
    chk("oc resume", obs, 8'h09);
    put(6'h22);
    cyc(200);
    put(6'h20);
    cyc(5);
    chk("uv glitch", flag_oe, 1'b0);
    put(6'h22);
    wait_obs(8'h40, 8'h40, 300);
    chk("uv delay", n >= 250 && n <= 257, 1'b1);
    cyc(3);
    chk("uv off", obs, 8'h40);
    chk("flag data", flag_n, 1'b0);
    put(6'h20);
    wait_obs(8'h40, 8'h00, 10);
    chk("uv recover", n < 10, 1'b1);
    put(6'h21);
    wait_obs(8'h40, 8'h40, 10);
    chk("ot flag", n < 8, 1'b1);
    cyc(3);
    chk("ot off", obs, 8'h40);
    put(6'h20);
    wait_obs(8'h0F, 8'h09, 30);
    chk("ot resume", obs, 8'h09);
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    cyc(2);
    chk("after reset", obs, 8'h80);
    t_wake();
    t_modes();
    t_sleep();
    t_fault();
    final_report();
  end
  // Watchdog well above the expected three and a half thousand cycles
  initial begin
    cyc(12000);
    n_mismatch++;
    final_report();
  end
endmodule // tb_bmh_ctrl

bind bmh_ctrl bmh_ctrl_monitor bmh_ctrl_monitor_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
  .dir_input_a_i(dir_input_a_i), .dir_input_b_i(dir_input_b_i), .overtemp_i(overtemp_i),
  .bridge_a_hs_o(bridge_a_hs_o), .bridge_a_ls_o(bridge_a_ls_o),
  .bridge_b_hs_o(bridge_b_hs_o), .bridge_b_ls_o(bridge_b_ls_o), .asleep_o(asleep_o),
  .fault_flag_n_oe_o(fault_flag_n_oe_o));
